// ### burst_sram_pkg.sv
// shared constants for the synchronous burst static ram port
package burst_sram_pkg;
	localparam int          ADDR_WIDTH_DEFAULT = 10;
	localparam int          LANES_DEFAULT      = 4;
	localparam int          FIFO_DEPTH_DEFAULT = 8;
	localparam int          BURST_BITS         = 2;
	localparam int          SLEEP_DELAY        = 2;
	localparam int          PIPE_LATENCY       = 2;
	localparam int          FLOW_LATENCY       = 1;
	localparam logic [1:0]  BURST_RESET        = 2'h0;
	localparam logic [1:0]  BURST_ONE          = 2'h1;

	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10,
		OP_DESEL = 2'b11
	} burst_op_e;
endpackage

// ### write_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module write_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      next_wr_ptr;
	logic [AW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	always_comb
	begin
		in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
		out_valid   = wr_ptr != rd_ptr;
		push        = clk_en && in_valid && in_ready;
		pop         = clk_en && out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		out_data    = mem[rd_ptr[AW-1:0]];
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule

// ### sync_burst_sram_port.sv
// device side of a late-write burst static ram with burst counter
`timescale 1ns/10ps
module sync_burst_sram_port
	import burst_sram_pkg::*;
#(
	parameter int ADDR_WIDTH = burst_sram_pkg::ADDR_WIDTH_DEFAULT,
	parameter int LANES      = burst_sram_pkg::LANES_DEFAULT,
	parameter int FIFO_DEPTH = burst_sram_pkg::FIFO_DEPTH_DEFAULT
) (
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic                  clock_hold_n,
	input  wire logic                  burst_step_select,
	input  wire logic                  write_n,
	input  wire logic [LANES-1:0]      byte_lane_enable_n,
	input  wire logic                  chip_select_1_n,
	input  wire logic                  chip_select_2,
	input  wire logic                  chip_select_3_n,
	input  wire logic                  output_enable_n,
	input  wire logic                  sleep_request,
	input  wire logic                  flow_mode_n,
	input  wire logic                  linear_order_n,
	input  wire logic                  ninth_bit_disable,
	input  wire logic                  drive_strength_sel,
	input  wire logic [ADDR_WIDTH-1:0] address,
	input  wire logic [LANES*8-1:0]    data_in,
	output logic [LANES*8-1:0]         data_out,
	output logic [LANES*8-1:0]         data_oe,
	input  wire logic [LANES-1:0]      ninth_bit_io_in,
	output logic [LANES-1:0]           ninth_bit_io_out,
	output logic [LANES-1:0]           ninth_bit_io_oe,
	output logic                       low_drive,
	output logic                       asleep
);
	import burst_sram_pkg::*;

	localparam int W     = LANES * 9;
	localparam int DEPTH = 1 << ADDR_WIDTH;

	initial
	begin
		if (ADDR_WIDTH < 3 || ADDR_WIDTH > 20 || LANES < 1)
			$error("unsupported address width or lane count");
	end

	// interleaved or linear address for a given burst count
	function automatic logic [1:0] burst_addr(input logic [1:0] start,
		input logic [1:0] count, input logic interleave);
		burst_addr = interleave ? (start ^ count) : 2'(start + count);
	endfunction

	// ============================================================
	// command decode and burst state
	// ============================================================
	logic [W-1:0]          mem [DEPTH];
	burst_op_e             op;
	burst_op_e             next_op;
	logic [ADDR_WIDTH-1:0] base;
	logic [ADDR_WIDTH-1:0] next_base;
	logic [1:0]            count;
	logic [1:0]            next_count;
	logic [1:0]            sleep_cnt;
	logic [1:0]            next_sleep_cnt;
	logic                  run;
	logic                  selected;
	logic                  load;
	logic                  cyc_read;
	logic                  cyc_write;
	logic [ADDR_WIDTH-1:0] cyc_addr;
	logic                  pipe_mode;

	// pins left open settle to the documented defaults in the pad ring
	assign pipe_mode = flow_mode_n;
	assign low_drive = drive_strength_sel;
	assign selected  = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	assign run       = clk_en && !clock_hold_n && !asleep;
	assign load      = !burst_step_select;

	always_comb
	begin
		next_op        = op;
		next_base      = base;
		next_count     = count;
		next_sleep_cnt = sleep_request ? ((sleep_cnt == 2'(SLEEP_DELAY)) ? sleep_cnt
			: 2'(sleep_cnt + 1'b1)) : 2'h0;
		cyc_read       = 1'b0;
		cyc_write      = 1'b0;
		cyc_addr       = address;
		if (run)
		begin
			if (load)
			begin
				next_count = BURST_RESET;
				next_base  = address;
				if (!selected)
					next_op = OP_DESEL;
				else if (write_n)
				begin
					next_op  = OP_READ;
					cyc_read = 1'b1;
				end
				else
				begin
					next_op   = OP_WRITE;
					cyc_write = 1'b1;
				end
			end
			else
			begin
				next_count = 2'(count + BURST_ONE);
				cyc_addr   = {base[ADDR_WIDTH-1:2],
					burst_addr(base[1:0], next_count, linear_order_n)};
				cyc_read   = (op == OP_READ);
				cyc_write  = (op == OP_WRITE);
			end // desel and idle continue stay floating
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			op        <= OP_IDLE;
			base      <= '0;
			count     <= BURST_RESET;
			sleep_cnt <= 2'h0;
		end
		else if (clk_en)
		begin
			op        <= next_op;
			base      <= next_base;
			count     <= next_count;
			sleep_cnt <= next_sleep_cnt;
		end
	end

	assign asleep = (sleep_cnt == 2'(SLEEP_DELAY));

	// ============================================================
	// late write pipeline through fifo
	// ============================================================
	// stage 1 holds the command for one more edge in pipeline mode
	logic                  wr1_valid;
	logic                  next_wr1_valid;
	logic [ADDR_WIDTH-1:0] wr1_addr;
	logic [LANES-1:0]      wr1_lanes;
	logic                  cmd_valid;
	logic [ADDR_WIDTH-1:0] cmd_addr;
	logic [LANES-1:0]      cmd_lanes;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic [ADDR_WIDTH+LANES-1:0] fifo_out;
	logic                  data_edge;
	logic [W-1:0]          wide_in;

	always_comb
	begin
		next_wr1_valid = wr1_valid;
		if (run)
			next_wr1_valid = cyc_write && pipe_mode;
		cmd_valid = pipe_mode ? (run && wr1_valid) : (run && cyc_write);
		cmd_addr  = pipe_mode ? wr1_addr : cyc_addr;
		cmd_lanes = pipe_mode ? wr1_lanes : byte_lane_enable_n;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			wr1_valid <= 1'b0;
		else if (clk_en)
			wr1_valid <= next_wr1_valid;
	end

	always_ff @(posedge ref_clk)
	begin
		if (clk_en && run)
		begin
			wr1_addr  <= cyc_addr;
			wr1_lanes <= byte_lane_enable_n;
		end
	end

	write_fifo #(
		.WIDTH(ADDR_WIDTH + LANES),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.in_data  ({cmd_addr, cmd_lanes}),
		.in_valid (cmd_valid),
		.in_ready (fifo_in_ready),
		.out_data (fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(data_edge)
	);

	// data edge: next run edge after the fifo holds a command
	assign data_edge = run;

	always_comb
	begin
		for (int i = 0; i < LANES; i++)
			wide_in[i*9 +: 9] = {ninth_bit_disable ? 1'b0 : ninth_bit_io_in[i],
				data_in[i*8 +: 8]};
	end

	always_ff @(posedge ref_clk)
	begin
		if (clk_en && data_edge && fifo_out_valid)
		begin
			for (int i = 0; i < LANES; i++)
				if (!fifo_out[i])
					mem[fifo_out[LANES +: ADDR_WIDTH]][i*9 +: 9] <= wide_in[i*9 +: 9];
		end
	end

	// ============================================================
	// read path and bus drivers
	// ============================================================
	logic [W-1:0] rd_word;
	logic [W-1:0] next_rd_word;
	logic         rd_drive;
	logic         next_rd_drive;
	logic [W-1:0] flow_word;
	logic         flow_drive;

	assign flow_word  = mem[cyc_addr];
	assign flow_drive = cyc_read;

	always_comb
	begin
		next_rd_word  = rd_word;
		next_rd_drive = rd_drive;
		if (run)
		begin
			next_rd_word  = flow_word;
			next_rd_drive = flow_drive;
		end
		else if (asleep)
			next_rd_drive = 1'b0;
	end // a stalled edge keeps the previous drive

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rd_word  <= '0;
			rd_drive <= 1'b0;
		end
		else if (clk_en)
		begin
			rd_word  <= next_rd_word;
			rd_drive <= next_rd_drive;
		end
	end

	// pipeline register delays one more edge; flow-through shows the registered word now
	logic [W-1:0] pipe_word;
	logic         pipe_drive;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pipe_word  <= '0;
			pipe_drive <= 1'b0;
		end
		else if (clk_en && run)
		begin
			pipe_word  <= rd_word;
			pipe_drive <= rd_drive;
		end
		else if (clk_en && asleep)
			pipe_drive <= 1'b0;
	end

	logic [W-1:0] out_word;
	logic         out_on;

	always_comb
	begin
		out_word = pipe_mode ? pipe_word : rd_word;
		out_on   = (pipe_mode ? pipe_drive : rd_drive) && !output_enable_n && !asleep;
		for (int i = 0; i < LANES; i++)
		begin
			data_out[i*8 +: 8]  = out_word[i*9 +: 8];
			data_oe[i*8 +: 8]   = {8{out_on}};
			ninth_bit_io_out[i] = out_word[i*9 + 8];
			ninth_bit_io_oe[i]  = out_on && !ninth_bit_disable;
		end
	end

	// ============================================================
	// checks
	// ============================================================
	sequence read_start_s;
		run && load && selected && write_n;
	endsequence

	reset_float_a: assert property (@(posedge ref_clk) reset |=> !(|data_oe))
		else $error("bus driven after reset");
	stall_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && clock_hold_n && !asleep |=> $stable(count) && $stable(op))
		else $error("state moved on an ignored edge");
	desel_float_a: assert property (@(posedge ref_clk) disable iff (reset)
		run && load && !selected |=> op == OP_DESEL && !rd_drive)
		else $error("deselect did not float");
	count_step_a: assert property (@(posedge ref_clk) disable iff (reset)
		run && !load |=> count == 2'($past(count) + 1'b1))
		else $error("counter did not advance");
	read_load_a: assert property (@(posedge ref_clk) disable iff (reset)
		read_start_s |=> op == OP_READ && count == BURST_RESET)
		else $error("read burst not loaded");
	write_off_a: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && run && cyc_write |=> !rd_drive)
		else $error("driver on during write");
	sleep_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && sleep_request ##1 clk_en && sleep_request |=> asleep)
		else $error("sleep not entered after two cycles");
	sleep_float_a: assert property (@(posedge ref_clk) asleep |-> !(|data_oe))
		else $error("outputs driven in sleep");
	desel_cont_a: assert property (@(posedge ref_clk) disable iff (reset)
		run && !load && op == OP_DESEL |=> op == OP_DESEL && !rd_drive)
		else $error("deselect continue left deselect");
	fifo_room_a: assert property (@(posedge ref_clk) disable iff (reset)
		cmd_valid |-> fifo_in_ready)
		else $error("write queue overflow");
endmodule

// ### host_model.sv
// host controller model: commands, byte lanes and write data
`timescale 1ns/10ps
module host_model (
	output logic        clock_hold_n,
	output logic        burst_step_select,
	output logic        write_n,
	output logic [3:0]  byte_lane_enable_n,
	output logic [2:0]  sel,
	output logic        output_enable_n,
	output logic [9:0]  address,
	output logic [35:0] bus
);
	initial
	begin
		cmd(1'b1, 1'b0, 1'b1, 4'hF, 3'h6, 1'b0, 10'h000);
		bus = 36'h0;
	end
	// one command per call; the caller applies it off the sampling edge
	task cmd(input logic hold, input logic step, input logic wr_n, input logic [3:0] ln,
		input logic [2:0] s, input logic oe_n, input logic [9:0] a);
		clock_hold_n       = hold;
		burst_step_select  = step;
		write_n            = wr_n;
		byte_lane_enable_n = ln;
		sel                = s;
		output_enable_n    = oe_n;
		address            = a;
	endtask
	// a released bus shows the inverse of its last value
	task put(input logic v, input logic [35:0] d);
		bus = v ? d : ~bus;
	endtask
endmodule

// ### sync_burst_sram_port_bench.sv
// self-checking bench for the burst static ram port
`timescale 1ns/10ps
module sync_burst_sram_port_bench;
	import burst_sram_pkg::*;
	logic        ref_clk            = 1'b0;
	logic        reset              = 1'b1;
	logic        sleep_request      = 1'b0;
	logic        flow_mode_n        = 1'b1;
	logic        linear_order_n     = 1'b0;
	logic        ninth_bit_disable  = 1'b0;
	logic        drive_strength_sel = 1'b1;
	logic        clock_hold_n;
	logic        burst_step_select;
	logic        write_n;
	logic [3:0]  byte_lane_enable_n;
	logic [2:0]  sel;
	logic        output_enable_n;
	logic [9:0]  address;
	logic [35:0] bus;
	logic [31:0] data_out;
	logic [31:0] data_oe;
	logic [3:0]  ninth_bit_io_out;
	logic [3:0]  ninth_bit_io_oe;
	logic        low_drive;
	logic        asleep;
	wire  [31:0] line;
	wire  [3:0]  line9;
	logic [35:0] mem [1024];
	int          n_fail             = 0;
	int          compares           = 0;

	always #5 ref_clk = ~ref_clk;
	// wire level resolved from the device's output enables; the host bus drives otherwise
	assign line  = (data_oe & data_out) | (~data_oe & bus[31:0]);
	assign line9 = (ninth_bit_io_oe & ninth_bit_io_out) | (~ninth_bit_io_oe & bus[35:32]);

	host_model host (.clock_hold_n(clock_hold_n), .burst_step_select(burst_step_select),
		.write_n(write_n), .byte_lane_enable_n(byte_lane_enable_n), .sel(sel),
		.output_enable_n(output_enable_n), .address(address), .bus(bus));

	sync_burst_sram_port dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.clock_hold_n(clock_hold_n), .burst_step_select(burst_step_select),
		.write_n(write_n), .byte_lane_enable_n(byte_lane_enable_n),
		.chip_select_1_n(sel[2]), .chip_select_2(sel[1]), .chip_select_3_n(sel[0]),
		.output_enable_n(output_enable_n), .sleep_request(sleep_request),
		.flow_mode_n(flow_mode_n), .linear_order_n(linear_order_n),
		.ninth_bit_disable(ninth_bit_disable), .drive_strength_sel(drive_strength_sel),
		.address(address), .data_in(line), .data_out(data_out), .data_oe(data_oe),
		.ninth_bit_io_in(line9), .ninth_bit_io_out(ninth_bit_io_out),
		.ninth_bit_io_oe(ninth_bit_io_oe), .low_drive(low_drive), .asleep(asleep));

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task end_of_test();
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [9:0] seq(input logic [9:0] s, input int k);
		logic [1:0] kk;
		kk = k[1:0];
		seq = {s[9:2], linear_order_n ? s[1:0] ^ kk : s[1:0] + kk};
	endfunction

	function automatic logic [35:0] pat(input logic [9:0] a, input logic [31:0] salt);
		pat = {a[3:0], a, 6'h2A, ~a, 6'h15} ^ {salt[3:0], salt};
	endfunction

	// load plus four continues, the last one wrapping to the start
	task automatic burst(input logic wr, input logic [9:0] s, input logic [3:0] ln,
		input int abort, input logic [31:0] salt);
		int          lat;
		int          k;
		logic [9:0]  a;
		logic [35:0] d;
		logic [35:0] m;
		lat = flow_mode_n ? PIPE_LATENCY : FLOW_LATENCY;
		m = {~{4{ninth_bit_disable}}, 32'hFFFFFFFF};
		for (int i = 0; i < lat + 7; i++)
		begin
			@(negedge ref_clk);
			k = i - lat;
			if (!wr && k >= 0 && k < 5)
			begin
				a = seq(s, k);
				check("read data", {ninth_bit_io_out, data_out} & m, mem[a] & m);
				check("read drive", {ninth_bit_io_oe, data_oe}, m);
			end
			if (wr)
				check("write float", {ninth_bit_io_oe, data_oe}, 36'h0);
			if (i == 0)
				host.cmd(1'b0, 1'b0, ~wr, abort == 0 ? 4'hF : ln, 3'h2, 1'b0, s);
			else if (i < 5)
				host.cmd(1'b0, 1'b1, wr, i == abort ? 4'hF : ln, 3'h5, 1'b0, ~s);
			else
				host.cmd(1'b0, 1'b0, 1'b1, 4'hF, 3'h6, 1'b0, 10'h000);
			k = i - lat;
			if (wr && k >= 0 && k < 5)
			begin
				a = seq(s, k);
				d = pat(a, salt);
				host.put(1'b1, d);
				for (int j = 0; j < 4; j++)
					if (!ln[j] && k != abort)
					begin
						mem[a][j*8+:8] = d[j*8+:8];
						mem[a][32+j]   = d[32+j];
					end
			end
			else
				host.put(1'b0, 36'h0);
		end
	endtask

	// pipelined read stalled three edges while its first word is out
	task automatic stall_read(input logic [9:0] s);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge ref_clk);
			if (i >= 2)
			begin
				check("stall data", {ninth_bit_io_out, data_out}, mem[seq(s, i < 6 ? 0 : i - 5)]);
				check("stall drive", {ninth_bit_io_oe, data_oe}, 36'hFFFFFFFFF);
			end
			host.cmd(i >= 2 && i < 5, i > 0 && i < 6, 1'b1, 4'hF, i < 6 ? 3'h2 : 3'h6, 1'b0, s);
		end
	endtask

	// each chip select deasserted alone, then a read with output enable high
	task automatic float_checks();
		logic [2:0] codes [4];
		codes = '{3'h6, 3'h0, 3'h3, 3'h2};
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 6; i++)
			begin
				@(negedge ref_clk);
				if (i > 0)
					check("float", {ninth_bit_io_oe, data_oe}, 36'h0);
				host.cmd(1'b0, i > 0, 1'b1, 4'hF, i > 0 ? 3'h2 : codes[c], c == 3, 10'h100);
			end
	endtask

	task automatic sleep_check();
		@(negedge ref_clk);
		sleep_request = 1'b1;
		@(negedge ref_clk);
		check("asleep early", 36'(asleep), 36'h0);
		@(negedge ref_clk);
		check("asleep", 36'(asleep), 36'h1);
		check("sleep float", {ninth_bit_io_oe, data_oe}, 36'h0);
		sleep_request = 1'b0;
		@(negedge ref_clk);
		check("awake", 36'(asleep), 36'h0);
	endtask

	initial
	begin
		#300us;
		n_fail++;
		end_of_test();
	end

	initial
	begin
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		check("reset float", {ninth_bit_io_oe, data_oe}, 36'h0);
		check("drive low", 36'(low_drive), 36'h1);
		drive_strength_sel = 1'b0;
		#1;
		check("drive high", 36'(low_drive), 36'h0);
		for (int f = 0; f < 2; f++)
		begin
			flow_mode_n = f[0];
			linear_order_n = 1'b0;
			burst(1'b1, f ? 10'h101 : 10'h041, 4'h0, 9, 32'h0);
			linear_order_n = 1'b1;
			burst(1'b0, f ? 10'h102 : 10'h042, 4'h0, 9, 32'h0);
			burst(1'b1, f ? 10'h103 : 10'h043, 4'hA, 2, 32'h5A5A0FF0);
			linear_order_n = 1'b0;
			burst(1'b0, f ? 10'h101 : 10'h041, 4'h0, 9, 32'h0);
		end
		stall_read(10'h101);
		float_checks();
		sleep_check();
		burst(1'b0, 10'h100, 4'h0, 9, 32'h0);
		ninth_bit_disable = 1'b1;
		burst(1'b0, 10'h040, 4'h0, 9, 32'h0);
		end_of_test();
	end
endmodule
